/* rtl/ds0_monitor_pkg.sv */
package ds0_monitor_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CTL_ONE     = 8'h03;
    localparam logic [7:0] IDX_CTL_TX      = 8'h19;
    localparam logic [7:0] IDX_TX_MON      = 8'h1A;
    localparam logic [7:0] IDX_CTL_RX      = 8'h1E;
    localparam logic [7:0] IDX_RX_MON      = 8'h1F;
    localparam logic [3:0] RX_SIG_PAGE     = 4'h6;
    localparam logic [3:0] TX_SIG_PAGE     = 4'h7;
    localparam logic [3:0] SIG_REG_COUNT   = 4'hC;
    localparam int         SIG_BITS        = 96;

    // Field positions
    localparam int         FORCE_ONES_BIT  = 5;
    localparam int         SEL_MSB         = 4;
    localparam logic [7:0] RX_CTL_MASK     = 8'h9F;

    // Values after reset
    localparam logic [7:0]  CTL_RESET      = 8'h00;
    localparam logic [7:0]  BYTE_RESET     = 8'h00;
    localparam logic [95:0] SIG_RESET      = 96'h0;
    localparam logic [31:0] RDATA_RESET    = 32'h0000_0000;

    // Frame structure counts
    localparam logic [4:0] LAST_CHANNEL    = 5'h17;
    localparam logic [2:0] LAST_BIT_IDX    = 3'h7;

    // Bus encodings
    localparam logic [1:0] HRESP_OKAY      = 2'h0;
    localparam logic [9:0] ADDR_ZERO_HI    = 10'h000;

    typedef enum logic [0:0] {
        CAP_WAIT  = 1'b0,
        CAP_FRAME = 1'b1
    } cap_state_t;

endpackage

/* rtl/ds0_byte_capture.sv */
`timescale 1ns/1ns
`default_nettype none

module ds0_byte_capture (
    input  wire logic       core_clk,
    input  wire logic       srst,
    input  wire logic       clk_en,
    input  wire logic       frame_sync,
    input  wire logic       bit_valid,
    input  wire logic       bit_in,
    input  wire logic [4:0] channel_select,
    output logic      [7:0] byte_q,
    output logic            byte_load_q
);

    ds0_monitor_pkg::cap_state_t state_q;
    logic [4:0] chan_q;
    logic [2:0] bit_q;
    logic [6:0] shift_q;
    logic       take;
    logic       sel_hit;
    logic       last_bit;

    // Payload bit of the current frame arrives
    assign take     = clk_en && bit_valid && !frame_sync && (state_q == ds0_monitor_pkg::CAP_FRAME);
    assign sel_hit  = (chan_q == channel_select);
    assign last_bit = (bit_q == ds0_monitor_pkg::LAST_BIT_IDX);

    // Channel and bit position within the frame
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_q <= ds0_monitor_pkg::CAP_WAIT;
            chan_q  <= 5'h00;
            bit_q   <= 3'h0;
        end else if (clk_en && bit_valid) begin
            if (frame_sync) begin
                state_q <= ds0_monitor_pkg::CAP_FRAME;
                chan_q  <= 5'h00;
                bit_q   <= 3'h0;
            end else begin
                unique case (state_q)
                    ds0_monitor_pkg::CAP_WAIT: begin
                        bit_q <= 3'h0;
                    end
                    ds0_monitor_pkg::CAP_FRAME: begin
                        bit_q <= bit_q + 3'h1;
                        if (last_bit) begin
                            chan_q <= chan_q + 5'h01;
                            if (chan_q == ds0_monitor_pkg::LAST_CHANNEL) begin
                                state_q <= ds0_monitor_pkg::CAP_WAIT;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // Shift in the selected channel, first bit ends up in the MSB
    always_ff @(posedge core_clk) begin
        if (srst) begin
            shift_q     <= 7'h00;
            byte_q      <= ds0_monitor_pkg::BYTE_RESET;
            byte_load_q <= 1'b0;
        end else if (clk_en) begin
            byte_load_q <= 1'b0;
            if (take && sel_hit) begin
                shift_q <= {shift_q[5:0], bit_in};
                if (last_bit) begin
                    byte_q      <= {shift_q, bit_in};
                    byte_load_q <= 1'b1;
                end
            end
        end
    end

    // Loads counted per frame, read only by the checks
    logic [1:0] loads_q;
    always_ff @(posedge core_clk) begin
        if (srst) begin
            loads_q <= 2'h0;
        end else if (clk_en && bit_valid && frame_sync) begin
            loads_q <= 2'h0;
        end else if (take && sel_hit && last_bit && loads_q != 2'h3) begin
            loads_q <= loads_q + 2'h1;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);

    sequence s_last_sel_bit;
        take && sel_hit && last_bit;
    endsequence

    sequence s_byte_out;
        byte_load_q && (byte_q == {$past(shift_q), $past(bit_in)});
    endsequence

    a_byte_bit_order: assert property (s_last_sel_bit |=> s_byte_out)
        else $error("monitor byte not assembled first bit in MSB");
    a_load_only_sel: assert property (take && !(sel_hit && last_bit) |=> !byte_load_q)
        else $error("monitor byte loaded from an unselected channel");
    a_once_per_frame: assert property (loads_q <= 2'h1)
        else $error("monitor byte loaded more than once in a frame");

endmodule

`default_nettype wire

/* rtl/ds0_channel_monitor.sv */
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none

// Contract
// - Five-bit transmit select, bit 4 MSB, picks the channel copied to transmit monitor.
// - Transmit monitor byte holds first transmitted bit in bit 7, last in bit 0.
// - Five-bit receive select, bit 4 MSB, picks the channel copied to receive monitor.
// - Receive monitor byte holds first received bit in bit 7, last in bit 0.
// - Force bit clear passes robbed signaling bits to serial output unchanged.
// - Force bit set drives every robbed signaling position on serial output to 1.
// - Register access and hardware signaling path work at once, neither disables other.
// - Twelve receive signaling registers report, twelve transmit signaling registers insert.
module ds0_channel_monitor (
    input  wire logic        core_clk,
    input  wire logic        srst,
    input  wire logic        clk_en,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic      [31:0] hrdata,
    output logic      [1:0]  hresp,
    input  wire logic        tx_frame_sync,
    input  wire logic        tx_bit_valid,
    input  wire logic        tx_bit,
    input  wire logic        rx_frame_sync,
    input  wire logic        rx_bit_valid,
    input  wire logic        rx_bit,
    input  wire logic        rx_robbed_position,
    output logic             receive_serial_output,
    input  wire logic        rx_sig_update,
    input  wire logic [95:0] rx_sig_data,
    output logic      [95:0] tx_sig_data
);

    logic [7:0]  common_control_one_q;
    logic [7:0]  common_control_one_d;
    logic [7:0]  common_control_tx_monitor_q;
    logic [7:0]  common_control_tx_monitor_d;
    logic [7:0]  common_control_rx_monitor_q;
    logic [7:0]  common_control_rx_monitor_d;
    logic [95:0] rx_signaling_register_q;
    logic [95:0] rx_signaling_register_d;
    logic [95:0] tx_signaling_register_q;
    logic [95:0] tx_signaling_register_d;
    logic [7:0]  tx_channel_monitor_byte;
    logic [7:0]  rx_channel_monitor_byte;
    logic [4:0]  tx_channel_select;
    logic [4:0]  rx_channel_select;
    logic        force_ones;

    logic        addr_ok;
    logic [7:0]  addr_idx;
    logic        accept;
    logic        wr_pend_q;
    logic [7:0]  wr_idx_q;
    logic        wr_commit;
    logic [31:0] rdata_q;

    // Control fields steering the datapath
    assign tx_channel_select = common_control_tx_monitor_q[ds0_monitor_pkg::SEL_MSB:0];
    assign rx_channel_select = common_control_rx_monitor_q[ds0_monitor_pkg::SEL_MSB:0];
    assign force_ones        = common_control_one_q[ds0_monitor_pkg::FORCE_ONES_BIT];

    // Address phase decode: word aligned, index in haddr[9:2]
    assign addr_ok   = (haddr[31:22] == ds0_monitor_pkg::ADDR_ZERO_HI) && (haddr[21:10] == 12'h000)
                       && (haddr[1:0] == 2'h0);
    assign addr_idx  = haddr[9:2];
    assign accept    = clk_en && hsel && hready && htrans[1];
    assign wr_commit = clk_en && wr_pend_q && hready;

    // Signaling register slot selector helpers
    function automatic logic sig_slot(input logic [7:0] idx, input logic [3:0] page);
        sig_slot = (idx[7:4] == page) && (idx[3:0] < ds0_monitor_pkg::SIG_REG_COUNT);
    endfunction

    function automatic logic [6:0] sig_base(input logic [7:0] idx);
        sig_base = {idx[3:0], 3'h0};
    endfunction

    // Next register values: hardware update and bus write
    always_comb begin
        common_control_one_d        = common_control_one_q;
        common_control_tx_monitor_d = common_control_tx_monitor_q;
        common_control_rx_monitor_d = common_control_rx_monitor_q;
        rx_signaling_register_d     = rx_signaling_register_q;
        tx_signaling_register_d     = tx_signaling_register_q;
        if (rx_sig_update) begin
            rx_signaling_register_d = rx_sig_data;
        end
        if (wr_commit) begin
            case (wr_idx_q)
                ds0_monitor_pkg::IDX_CTL_ONE: begin
                    common_control_one_d = hwdata[7:0];
                end
                ds0_monitor_pkg::IDX_CTL_TX: begin
                    common_control_tx_monitor_d = hwdata[7:0];
                end
                ds0_monitor_pkg::IDX_CTL_RX: begin
                    common_control_rx_monitor_d = hwdata[7:0] & ds0_monitor_pkg::RX_CTL_MASK;
                end
                default: begin
                    if (sig_slot(wr_idx_q, ds0_monitor_pkg::TX_SIG_PAGE)) begin
                        tx_signaling_register_d[sig_base(wr_idx_q) +: 8] = hwdata[7:0];
                    end
                end
            endcase
        end
    end

    // Control registers
    always_ff @(posedge core_clk) begin
        if (srst) begin
            common_control_one_q        <= ds0_monitor_pkg::CTL_RESET;
            common_control_tx_monitor_q <= ds0_monitor_pkg::CTL_RESET;
            common_control_rx_monitor_q <= ds0_monitor_pkg::CTL_RESET;
        end else if (clk_en) begin
            common_control_one_q        <= common_control_one_d;
            common_control_tx_monitor_q <= common_control_tx_monitor_d;
            common_control_rx_monitor_q <= common_control_rx_monitor_d;
        end
    end

    // Signaling register banks
    always_ff @(posedge core_clk) begin
        if (srst) begin
            rx_signaling_register_q <= ds0_monitor_pkg::SIG_RESET;
            tx_signaling_register_q <= ds0_monitor_pkg::SIG_RESET;
        end else if (clk_en) begin
            rx_signaling_register_q <= rx_signaling_register_d;
            tx_signaling_register_q <= tx_signaling_register_d;
        end
    end

    assign tx_sig_data = tx_signaling_register_q;

    // Read value, taken from next values so a write just ahead is seen
    function automatic logic [31:0] read_word(input logic [7:0] idx);
        logic [7:0] val;
        val = 8'h00;
        if (idx == ds0_monitor_pkg::IDX_CTL_ONE) begin
            val = common_control_one_d;
        end else if (idx == ds0_monitor_pkg::IDX_CTL_TX) begin
            val = common_control_tx_monitor_d;
        end else if (idx == ds0_monitor_pkg::IDX_TX_MON) begin
            val = tx_channel_monitor_byte;
        end else if (idx == ds0_monitor_pkg::IDX_CTL_RX) begin
            val = common_control_rx_monitor_d;
        end else if (idx == ds0_monitor_pkg::IDX_RX_MON) begin
            val = rx_channel_monitor_byte;
        end else if (sig_slot(idx, ds0_monitor_pkg::RX_SIG_PAGE)) begin
            val = rx_signaling_register_d[sig_base(idx) +: 8];
        end else if (sig_slot(idx, ds0_monitor_pkg::TX_SIG_PAGE)) begin
            val = tx_signaling_register_d[sig_base(idx) +: 8];
        end
        read_word = {24'h000000, val};
    endfunction

    // Bus slave: zero wait, write lands in its data phase
    always_ff @(posedge core_clk) begin
        if (srst) begin
            wr_pend_q <= 1'b0;
            wr_idx_q  <= 8'h00;
            rdata_q   <= ds0_monitor_pkg::RDATA_RESET;
        end else if (clk_en) begin
            if (accept) begin
                wr_pend_q <= hwrite && addr_ok;
                wr_idx_q  <= addr_idx;
                if (!hwrite) begin
                    rdata_q <= addr_ok ? read_word(addr_idx) : ds0_monitor_pkg::RDATA_RESET;
                end
            end else if (hready) begin
                wr_pend_q <= 1'b0;
            end
        end
    end

    // Fixed handshake and response flops
    always_ff @(posedge core_clk) begin
        if (srst) begin
            hreadyout <= 1'b1;
            hresp     <= ds0_monitor_pkg::HRESP_OKAY;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= ds0_monitor_pkg::HRESP_OKAY;
        end
    end

    assign hrdata = rdata_q;

    // Receive serial output with optional forcing of robbed positions
    always_ff @(posedge core_clk) begin
        if (srst) begin
            receive_serial_output <= 1'b1;
        end else if (clk_en && rx_bit_valid) begin
            if (force_ones && rx_robbed_position) begin
                receive_serial_output <= 1'b1;
            end else begin
                receive_serial_output <= rx_bit;
            end
        end
    end

    // Transmit channel monitor
    ds0_byte_capture u_tx_capture (
        .core_clk       (core_clk),
        .srst           (srst),
        .clk_en         (clk_en),
        .frame_sync     (tx_frame_sync),
        .bit_valid      (tx_bit_valid),
        .bit_in         (tx_bit),
        .channel_select (tx_channel_select),
        .byte_q         (tx_channel_monitor_byte),
        .byte_load_q    ()
    );

    // Receive channel monitor
    ds0_byte_capture u_rx_capture (
        .core_clk       (core_clk),
        .srst           (srst),
        .clk_en         (clk_en),
        .frame_sync     (rx_frame_sync),
        .bit_valid      (rx_bit_valid),
        .bit_in         (rx_bit),
        .channel_select (rx_channel_select),
        .byte_q         (rx_channel_monitor_byte),
        .byte_load_q    ()
    );

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);

    sequence s_rd_tx_mon;
        accept && !hwrite && addr_ok && (addr_idx == ds0_monitor_pkg::IDX_TX_MON);
    endsequence

    sequence s_rd_rx_mon;
        accept && !hwrite && addr_ok && (addr_idx == ds0_monitor_pkg::IDX_RX_MON);
    endsequence

    sequence s_wr_tx_ctl;
        accept && hwrite && addr_ok && (addr_idx == ds0_monitor_pkg::IDX_CTL_TX);
    endsequence

    a_force_ones_out: assert property (clk_en && rx_bit_valid && force_ones && rx_robbed_position
                                       |=> receive_serial_output)
        else $error("robbed position not forced to one");
    a_pass_robbed_bit: assert property (clk_en && rx_bit_valid && !force_ones
                                        |=> receive_serial_output == $past(rx_bit))
        else $error("serial output differs from received bit");
    a_rd_tx_monitor: assert property (s_rd_tx_mon |=> hrdata == {24'h000000, $past(tx_channel_monitor_byte)})
        else $error("transmit monitor read returned wrong byte");
    a_rd_rx_monitor: assert property (s_rd_rx_mon |=> hrdata == {24'h000000, $past(rx_channel_monitor_byte)})
        else $error("receive monitor read returned wrong byte");
    a_tx_select_write: assert property (s_wr_tx_ctl ##1 (clk_en && hready)
                                        |=> tx_channel_select == $past(hwdata[4:0]))
        else $error("transmit select not taken from write");
    a_rx_unassigned_zero: assert property (common_control_rx_monitor_q[6:5] == 2'h0)
        else $error("receive control unassigned bits not zero");
    a_rx_sig_update: assert property (clk_en && rx_sig_update && !wr_commit
                                      |=> rx_signaling_register_q == $past(rx_sig_data))
        else $error("receive signaling bank not updated");
    a_hw_path_alive: assert property (clk_en && rx_bit_valid && !force_ones && wr_pend_q
                                      |=> receive_serial_output == $past(rx_bit))
        else $error("serial path stalled by register access");

    sequence s_wr_rx_ctl;
        accept && hwrite && addr_ok && (addr_idx == ds0_monitor_pkg::IDX_CTL_RX);
    endsequence

    sequence s_wr_ctl_one;
        accept && hwrite && addr_ok && (addr_idx == ds0_monitor_pkg::IDX_CTL_ONE);
    endsequence

    sequence s_commit;
        clk_en && hready;
    endsequence

    // Writes reach the receive select and the force bit
    a_rx_select_write: assert property (s_wr_rx_ctl ##1 s_commit
                                        |=> rx_channel_select == $past(hwdata[4:0]))
        else $error("receive select not taken from write");
    a_force_bit_write: assert property (s_wr_ctl_one ##1 s_commit
                                        |=> force_ones == $past(hwdata[ds0_monitor_pkg::FORCE_ONES_BIT]))
        else $error("force bit not taken from write");

    // Receive signaling bank moves only on its strobe
    a_rx_sig_read_only: assert property (clk_en && !rx_sig_update
                                         |=> rx_signaling_register_q == $past(rx_signaling_register_q))
        else $error("receive signaling bank changed without strobe");

    // Bus always answers at once with OKAY
    a_bus_okay: assert property (hreadyout && (hresp == ds0_monitor_pkg::HRESP_OKAY))
        else $error("bus answer not ready or not okay");

    // Low clock enable freezes selects and serial output
    a_select_frozen: assert property (!clk_en |=> $stable(tx_channel_select) && $stable(rx_channel_select))
        else $error("channel select moved while frozen");
    a_serial_frozen: assert property (!clk_en |=> $stable(receive_serial_output))
        else $error("serial output moved while frozen");

endmodule

`default_nettype wire

/* testbench/t1_stream_model.sv */
`timescale 1ns/1ns
`default_nettype none

module t1_stream_model (
    input  wire logic         core_clk,
    input  wire logic         srst,
    input  wire logic         go,
    input  wire logic [191:0] payload,
    input  wire logic         rob_en,
    input  wire logic [1:0]   gap,
    output logic              frame_sync,
    output logic              bit_valid,
    output logic              bit_out,
    output logic              robbed,
    output logic              busy
);
    int i;

    // One frame per request: F bit, then 24 channels, first bit of a byte first
    initial begin
        frame_sync = 1'b0;
        bit_valid  = 1'b0;
        bit_out    = 1'b0;
        robbed     = 1'b0;
        busy       = 1'b0;
        forever begin
            @(posedge core_clk);
            if (go && !srst) begin
                busy <= 1'b1;
                for (i = -1; i < 192; i++) begin
                    frame_sync <= (i < 0);
                    bit_valid  <= 1'b1;
                    bit_out    <= (i < 0) ? 1'b1 : payload[191 - i];
                    robbed     <= rob_en && (i >= 0) && (i % 8 == 7);
                    @(posedge core_clk);
                    if (gap != 2'h0) begin
                        bit_valid <= 1'b0;
                        bit_out   <= ~bit_out; // Idle line never shows the last bit
                        repeat (gap) @(posedge core_clk);
                    end
                end
                bit_valid  <= 1'b0;
                frame_sync <= 1'b0;
                robbed     <= 1'b0;
                busy       <= 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none

module tb_top;
    logic         core_clk = 1'b0;
    logic         srst = 1'b1;
    logic         hsel = 1'b0;
    logic [31:0]  haddr = 32'h0;
    logic [1:0]   htrans = 2'h0;
    logic         hwrite = 1'b0;
    logic [2:0]   hsize = 3'h0;
    logic         ce = 1'b1;
    logic [31:0]  hwdata = 32'h0;
    logic         hready;
    logic         hreadyout;
    logic [31:0]  hrdata;
    logic [1:0]   hresp;
    logic         tx_sync, tx_valid, tx_bit_w, rx_sync, rx_valid, rx_bit_w, rx_rob, ser_out;
    logic         rx_sig_update = 1'b0;
    logic [95:0]  rx_sig_data = 96'h0;
    logic [95:0]  tx_sig_data;
    logic         go_tx = 1'b0, go_rx = 1'b0, busy_tx, busy_rx, ser_pend = 1'b0, ser_exp = 1'b0;
    logic [191:0] pay_tx = 192'h0, pay_rx = 192'h0, pt, pr;
    logic [1:0]   gap_tx = 2'h0, gap_rx = 2'h0;
    logic [31:0]  rng_state = 32'h0000B126, d, r;
    logic [7:0]   ctl_tx_m = 8'h00, ctl_rx_m = 8'h00, ctl_one_m = 8'h00, txm_m = 8'h00, rxm_m = 8'h00;
    logic [95:0]  sg;
    int           failures = 0, n_checks = 0, k, st, sr, n;
    int           sels[6] = '{0, 23, 5, 14, 0, 24};

    assign hready = hreadyout;
    always #50 core_clk = ~core_clk;

    ds0_channel_monitor dut (.core_clk(core_clk), .srst(srst), .clk_en(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .tx_frame_sync(tx_sync),
        .tx_bit_valid(tx_valid), .tx_bit(tx_bit_w), .rx_frame_sync(rx_sync), .rx_bit_valid(rx_valid),
        .rx_bit(rx_bit_w), .rx_robbed_position(rx_rob), .receive_serial_output(ser_out),
        .rx_sig_update(rx_sig_update), .rx_sig_data(rx_sig_data), .tx_sig_data(tx_sig_data));
    t1_stream_model u_tx_src (.core_clk(core_clk), .srst(srst), .go(go_tx), .payload(pay_tx),
        .rob_en(1'b0), .gap(gap_tx), .frame_sync(tx_sync), .bit_valid(tx_valid), .bit_out(tx_bit_w),
        .robbed(), .busy(busy_tx));
    t1_stream_model u_rx_src (.core_clk(core_clk), .srst(srst), .go(go_rx), .payload(pay_rx),
        .rob_en(1'b1), .gap(gap_rx), .frame_sync(rx_sync), .bit_valid(rx_valid), .bit_out(rx_bit_w),
        .robbed(rx_rob), .busy(busy_rx));

    function automatic logic [31:0] rnd();
        rng_state = rng_state ^ (rng_state << 13);
        rng_state = rng_state ^ (rng_state >> 17);
        rng_state = rng_state ^ (rng_state << 5);
        return rng_state;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Single AHB-Lite transfer, entered just after a rising edge
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= {22'h0, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize  <= 3'h2;
        @(posedge core_clk);
        while (hready !== 1'b1) @(posedge core_clk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge core_clk);
        while (hready !== 1'b1) @(posedge core_clk);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] v);
        logic [31:0] dummy;
        bus(1'b1, idx, v, dummy);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp, input string what);
        logic [31:0] v;
        bus(1'b0, idx, rnd(), v);
        check(v, {24'h0, exp}, what);
    endtask

    // Serial output follows each receive bit one edge later, or is 1 at a robbed position while the force bit is set
    always @(posedge core_clk) begin
        ser_pend <= rx_valid && !srst;
        ser_exp  <= (ctl_one_m[5] && rx_rob) ? 1'b1 : rx_bit_w;
    end
    always @(negedge core_clk) if (ser_pend) check({31'h0, ser_out}, {31'h0, ser_exp}, "serial_out");

    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        wrap_up();
    end

    initial begin
        repeat (8) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        check({29'h0, hreadyout, hresp}, 32'h4, "bus_idle");
        check({31'h0, ser_out}, 32'h1, "serial_reset");
        check(tx_sig_data[31:0], 32'h0, "tx_sig_reset");
        rd_chk(ds0_monitor_pkg::IDX_CTL_ONE, 8'h00, "ctl_one_reset");
        rd_chk(ds0_monitor_pkg::IDX_CTL_TX, 8'h00, "ctl_tx_reset");
        rd_chk(ds0_monitor_pkg::IDX_TX_MON, 8'h00, "tx_mon_reset");
        rd_chk(ds0_monitor_pkg::IDX_CTL_RX, 8'h00, "ctl_rx_reset");
        rd_chk(ds0_monitor_pkg::IDX_RX_MON, 8'h00, "rx_mon_reset");
        rd_chk(8'h05, 8'h00, "unmapped");
        wr(ds0_monitor_pkg::IDX_TX_MON, rnd());
        rd_chk(ds0_monitor_pkg::IDX_TX_MON, 8'h00, "tx_mon_ro");
        wr(ds0_monitor_pkg::IDX_CTL_RX, 32'hFF);
        rd_chk(ds0_monitor_pkg::IDX_CTL_RX, 8'h9F, "ctl_rx_mask");
        // Frames with assorted selects, spacing and force setting
        for (k = 0; k < 6; k++) begin
            st = (k == 4) ? (rnd() % 24) : sels[k];
            sr = (k == 5) ? 31 : (st + 7) % 24;
            d = rnd();
            ctl_tx_m = {d[7:5], st[4:0]};
            ctl_rx_m = {d[7], 2'b00, sr[4:0]};
            ctl_one_m = {d[7:6], k[0], d[4:0]};
            wr(ds0_monitor_pkg::IDX_CTL_TX, {d[31:8], ctl_tx_m});
            wr(ds0_monitor_pkg::IDX_CTL_RX, {d[31:8], ctl_rx_m});
            wr(ds0_monitor_pkg::IDX_CTL_ONE, {d[31:8], ctl_one_m});
            pt = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
            pr = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
            pay_tx <= pt;
            pay_rx <= pr;
            gap_tx <= k[1:0];
            gap_rx <= d[9:8];
            go_tx <= 1'b1;
            go_rx <= 1'b1;
            @(posedge core_clk);
            go_tx <= 1'b0;
            go_rx <= 1'b0;
            // Register traffic while both streams run
            wr(ds0_monitor_pkg::IDX_CTL_ONE, {d[31:8], ctl_one_m});
            rd_chk(ds0_monitor_pkg::IDX_CTL_RX, ctl_rx_m, "ctl_rx_live");
            @(negedge core_clk);
            while (busy_tx || busy_rx) @(negedge core_clk);
            @(posedge core_clk);
            if (st < 24) txm_m = pt[191 - 8 * st -: 8];
            if (sr < 24) rxm_m = pr[191 - 8 * sr -: 8];
            rd_chk(ds0_monitor_pkg::IDX_TX_MON, txm_m, "tx_mon");
            rd_chk(ds0_monitor_pkg::IDX_RX_MON, rxm_m, "rx_mon");
            rd_chk(ds0_monitor_pkg::IDX_CTL_TX, ctl_tx_m, "ctl_tx");
            rd_chk(ds0_monitor_pkg::IDX_CTL_ONE, ctl_one_m, "ctl_one");
        end
        // Frozen core ignores the signaling strobe
        ce <= 1'b0;
        rx_sig_update <= 1'b1;
        rx_sig_data <= ~96'h0;
        repeat (3) @(posedge core_clk);
        ce <= 1'b1;
        rx_sig_update <= 1'b0;
        rd_chk({ds0_monitor_pkg::RX_SIG_PAGE, 4'h0}, 8'h00, "rx_sig_frozen");
        // Signaling registers alongside the hardware path
        ctl_one_m = 8'h00;
        wr(ds0_monitor_pkg::IDX_CTL_ONE, 32'h0);
        sg = {rnd(), rnd(), rnd()};
        rx_sig_data <= sg;
        rx_sig_update <= 1'b1;
        for (n = 0; n < 12; n++) begin
            d = rnd();
            wr({ds0_monitor_pkg::TX_SIG_PAGE, n[3:0]}, d);
            rx_sig_update <= 1'b0;
            rd_chk({ds0_monitor_pkg::TX_SIG_PAGE, n[3:0]}, d[7:0], "tx_sig_reg");
            check({24'h0, tx_sig_data[8 * n +: 8]}, {24'h0, d[7:0]}, "tx_sig_data");
            rd_chk({ds0_monitor_pkg::RX_SIG_PAGE, n[3:0]}, sg[8 * n +: 8], "rx_sig_reg");
        end
        wr({ds0_monitor_pkg::RX_SIG_PAGE, 4'h0}, {24'h0, ~sg[7:0]});
        rd_chk({ds0_monitor_pkg::RX_SIG_PAGE, 4'h0}, sg[7:0], "rx_sig_ro");
        wrap_up();
    end
endmodule

`default_nettype wire
